// ===== rtl/sram_host_ctrl.sv
//
// Overview of operation
// - select low with write strobe high is a read and the device drives the addressed bit.
// - a write begins when the later of select and write strobe falls so that both are low.
// - the host drives write data only after the write-to-off delay from the strobe falling.
// - for a strobe-ended write the host meets data set-up and hold around the rising strobe.
// - for a select-ended write set-up and hold refer to select rising and the output stays floating.
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl
    import sram_host_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // user request
    input wire logic req_valid_i,
    input wire logic req_write_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic req_wdata_i,
    output logic req_ready_o,
    output logic rd_valid_o,
    output logic rd_data_o,
    // device pins
    output logic chip_select_low_o,
    output logic write_strobe_low_o,
    output logic [ADDR_W-1:0] addr_lines_o,
    output logic data_in_o,
    output logic data_in_oe_o,
    input wire logic data_out_i
);
    host_state_t state_ff;
    host_state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic cs_n_ff;
    logic we_n_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic wdata_ff;
    logic din_oe_ff;
    logic rd_valid_ff;
    logic rd_data_ff;
    logic q_meta_ff;
    logic q_sync_ff;
    // two pin synchroniser stages lengthen every read wait
    localparam int SYNC_CYC = 2;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // data output comes from a pin: two flops before use
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_meta_ff <= 1'b0;
            q_sync_ff <= 1'b0;
        end else begin
            q_meta_ff <= data_out_i;
            q_sync_ff <= q_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign req_ready_o = (state_ff == ST_IDLE);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (req_valid_i) begin
                    // select falls on the same edge that loads the address; the wait is fixed, not idle-dependent
                    nxt_state = req_write_i ? ST_WR_SETUP : ST_RD_ACC;
                    // sync delay of two cycles is added to the access wait
                    nxt_cnt = req_write_i ? cyc(SETUP_CYC) : cyc(ACCESS_CYC + SYNC_CYC);
                end
            end
            ST_RD_ACC: begin
                if (cnt_ff == '0) begin
                    nxt_state = ST_RECOVER;
                    nxt_cnt = cyc(HIZ_CYC);
                end
            end
            ST_WR_SETUP: begin
                if (cnt_ff == '0) begin
                    nxt_state = ST_WR_OFF;
                    nxt_cnt = cyc(OFF_CYC);
                end
            end
            ST_WR_OFF: begin
                if (cnt_ff == '0) begin
                    nxt_state = ST_WR_DATA;
                    nxt_cnt = cyc((DSETUP_CYC > PULSE_CYC) ? DSETUP_CYC : PULSE_CYC);
                end
            end
            ST_WR_DATA: begin
                if (cnt_ff == '0) begin
                    nxt_state = ST_WR_HOLD;
                    nxt_cnt = cyc(HOLD_CYC);
                end
            end
            ST_WR_HOLD: begin
                if (cnt_ff == '0) begin
                    nxt_state = ST_RECOVER;
                    nxt_cnt = cyc(HIZ_CYC);
                end
            end
            ST_RECOVER: begin
                if (cnt_ff == '0) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins are registered so they change cleanly on one edge
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            addr_ff <= '0;
            wdata_ff <= 1'b0;
            din_oe_ff <= 1'b0;
        end else begin
            // select only falls from idle, so address never moves while selected
            cs_n_ff <= !(nxt_state inside {ST_RD_ACC, ST_WR_SETUP, ST_WR_OFF, ST_WR_DATA, ST_WR_HOLD});
            // strobe falls after select; write ends on strobe rising, select stays low one hold span
            we_n_ff <= !(nxt_state inside {ST_WR_OFF, ST_WR_DATA});
            // data held past strobe rise so hold is met
            din_oe_ff <= (nxt_state inside {ST_WR_DATA, ST_WR_HOLD});
            if (state_ff == ST_IDLE && req_valid_i) begin
                addr_ff <= req_addr_i;
                wdata_ff <= req_wdata_i;
            end
        end
    end

    assign chip_select_low_o = cs_n_ff;
    assign write_strobe_low_o = we_n_ff;
    assign addr_lines_o = addr_ff;
    assign data_in_o = wdata_ff;
    assign data_in_oe_o = din_oe_ff;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 1'b0;
        end else begin
            rd_valid_ff <= (state_ff == ST_RD_ACC) && (cnt_ff == '0);
            if ((state_ff == ST_RD_ACC) && (cnt_ff == '0)) begin
                rd_data_ff <= q_sync_ff;
            end
        end
    end

    assign rd_valid_o = rd_valid_ff;
    assign rd_data_o = rd_data_ff;

    ////////////////////////////////////////////////////////////////////////////
    strobe_after_sel_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $fell(write_strobe_low_o) |-> $past(!chip_select_low_o)) else $error("strobe fell without select");
    data_after_off_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(data_in_oe_o) |-> $past(!write_strobe_low_o, 2)) else $error("data driven too early");
    hold_after_rise_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(write_strobe_low_o) |-> data_in_oe_o && !chip_select_low_o) else $error("hold missed");
    idle_pins_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        chip_select_low_o |-> write_strobe_low_o && !data_in_oe_o) else $error("pins active while idle");
    addr_stable_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !chip_select_low_o && $past(!chip_select_low_o) |-> $stable(addr_lines_o)) else $error("address moved");
    read_wait_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(rd_valid_o) |-> $past(!chip_select_low_o, 2)) else $error("read sampled unselected");
    read_no_strobe_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        state_ff == ST_RD_ACC |-> write_strobe_low_o) else $error("strobe low in read");
    pulse_width_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $fell(write_strobe_low_o) |-> !write_strobe_low_o [*3]) else $error("write pulse short");
    // whole-transfer shapes; counts follow the package timing at a 20 ns clock
    read_shape_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        req_ready_o && req_valid_i && !req_write_i |=> !chip_select_low_o [*6] ##1 (chip_select_low_o && rd_valid_o)) else $error("read shape wrong");
    write_shape_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        req_ready_o && req_valid_i && req_write_i |=> (!chip_select_low_o && write_strobe_low_o) ##1 !write_strobe_low_o [*4] ##1 (write_strobe_low_o && data_in_oe_o && !chip_select_low_o) ##1 chip_select_low_o) else $error("write shape wrong");
    rd_pulse_one_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        rd_valid_o |=> !rd_valid_o) else $error("read valid too long");
    ready_idle_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        req_ready_o |-> chip_select_low_o && write_strobe_low_o && !data_in_oe_o) else $error("ready while busy");
    rd_data_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !rd_valid_o |-> $stable(rd_data_o)) else $error("read data moved");
    addr_capture_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        req_ready_o && req_valid_i |=> addr_lines_o == $past(req_addr_i)) else $error("address not taken");
    data_wait_off_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $fell(write_strobe_low_o) |-> !data_in_oe_o [*2]) else $error("data inside off delay");
    strobe_in_sel_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !write_strobe_low_o |-> !chip_select_low_o && !req_ready_o) else $error("strobe outside select");
    sel_first_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $fell(chip_select_low_o) |-> write_strobe_low_o) else $error("select fell with strobe low");
endmodule // sram_host_ctrl
`default_nettype wire

// ===== rtl/sram_host_pkg.sv
package sram_host_pkg;
    // bus geometry
    localparam int ADDR_W = 16;
    localparam int CELL_COUNT = 65536;
    localparam int CLK_PERIOD_NS = 20;
    // device timing, nanoseconds as printed for the slowest grade
    localparam int ACCESS_NS = 70;
    localparam int CYCLE_NS = 70;
    localparam int WRITE_PULSE_NS = 30;
    localparam int DATA_SETUP_NS = 30;
    localparam int DATA_HOLD_NS = 5;
    localparam int ADDR_SETUP_NS = 7;
    localparam int WRITE_TO_OUTPUT_OFF_NS = 30;
    localparam int DESELECT_HIZ_NS = 30;
    // least times round up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int ACCESS_CYC = ns_to_cyc(ACCESS_NS);
    localparam int SETUP_CYC = ns_to_cyc(ADDR_SETUP_NS);
    localparam int OFF_CYC = ns_to_cyc(WRITE_TO_OUTPUT_OFF_NS);
    localparam int PULSE_CYC = ns_to_cyc(WRITE_PULSE_NS);
    localparam int DSETUP_CYC = ns_to_cyc(DATA_SETUP_NS);
    localparam int HOLD_CYC = ns_to_cyc(DATA_HOLD_NS);
    localparam int HIZ_CYC = ns_to_cyc(DESELECT_HIZ_NS);
    localparam int CNT_W = 4;
    // host sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD_ACC = 3'b001,
        ST_WR_SETUP = 3'b010,
        ST_WR_OFF = 3'b011,
        ST_WR_DATA = 3'b100,
        ST_WR_HOLD = 3'b101,
        ST_RECOVER = 3'b110
    } host_state_t;
endpackage

// ===== verif/sram_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module sram_dev_model
    import sram_host_pkg::*;
(
    // clock
    input wire logic clk_i,
    // device pins
    input wire logic chip_select_low_i,
    input wire logic write_strobe_low_i,
    input wire logic [ADDR_W-1:0] addr_lines_i,
    input wire logic data_in_i,
    output logic data_out_o
);
    logic mem [CELL_COUNT];
    logic cs_q = 1'b1;
    logic we_q = 1'b1;
    logic ending;
    ////////////////////////////////////////////////////////////////////////////////
    // whichever control rises first while both were low ends the write
    assign ending = !cs_q && !we_q && (chip_select_low_i || write_strobe_low_i);
    always @(posedge clk_i) begin
        cs_q <= chip_select_low_i;
        we_q <= write_strobe_low_i;
        if (ending) begin
            mem[addr_lines_i] <= data_in_i;
        end
        if (!chip_select_low_i && write_strobe_low_i) begin
            data_out_o <= ending ? data_in_i : mem[addr_lines_i];
        end else begin
            // floating pin toggles so a stale bit never passes for data
            data_out_o <= (data_out_o !== 1'b1);
        end
    end
endmodule // sram_dev_model
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sram_host_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [ADDR_W-1:0] req_addr_i = '0;
    logic req_wdata_i = 1'b0;
    logic req_ready_o, rd_valid_o, rd_data_o, chip_select_low_o, write_strobe_low_o;
    logic [ADDR_W-1:0] addr_lines_o;
    logic data_in_o, data_in_oe_o, data_out_w, din_w;
    logic flip_ff = 1'b0;
    int errors = 0;
    int num_checks = 0;
    // pin synchroniser adds two cycles on top of the access wait
    localparam int RD_LAT = ACCESS_CYC + 2;
    bit exp_mem [int];
    logic [ADDR_W-1:0] used [$];
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // undriven data wire wanders instead of holding the last bit
    always @(posedge clk_sys_i) flip_ff <= ~flip_ff;
    assign din_w = data_in_oe_o ? data_in_o : flip_ff;
    sram_host_ctrl sram_host_ctrl_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .chip_select_low_o(chip_select_low_o), .write_strobe_low_o(write_strobe_low_o),
        .addr_lines_o(addr_lines_o), .data_in_o(data_in_o), .data_in_oe_o(data_in_oe_o),
        .data_out_i(data_out_w));
    sram_dev_model sram_dev_model_inst (.clk_i(clk_sys_i), .chip_select_low_i(chip_select_low_o),
        .write_strobe_low_i(write_strobe_low_o), .addr_lines_i(addr_lines_o), .data_in_i(din_w),
        .data_out_o(data_out_w));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %b got %b", what, exp, got);
        end
    endtask
    task automatic cmp_lat(input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            errors++;
            $display("BAD read latency exp %0d got %0d", exp, got);
        end
    endtask
    // entered and left just after a clock edge
    task automatic do_req(input logic wr, input logic [ADDR_W-1:0] a, input logic d);
        int k;
        req_valid_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        req_wdata_i = d;
        for (k = 0; k < 20 && req_ready_o !== 1'b1; k++) begin
            @(posedge clk_sys_i);
            #1;
        end
        @(posedge clk_sys_i);
        #1;
        req_valid_i = 1'b0;
        if (wr) begin
            exp_mem[a] = d;
            used.push_back(a);
            // let an edge pass so the next request never re-raises valid in this time step
            @(posedge clk_sys_i);
            #1;
        end else begin
            for (k = 1; k < 12; k++) begin
                @(posedge clk_sys_i);
                #1;
                if (k == 3) cmp_bit("read strobe", 1'b1, write_strobe_low_o);
                if (rd_valid_o === 1'b1) break;
            end
            cmp_lat(RD_LAT, k);
            cmp_bit("read data", exp_mem[a], rd_data_o);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic wr;
        logic [ADDR_W-1:0] a;
        void'($urandom(32'h5DB94452));
        repeat (12) @(posedge clk_sys_i);
        #1;
        nrst_i = 1'b1;
        // address extremes, back to back, then overwrite
        do_req(1'b1, 16'h0000, 1'b1);
        do_req(1'b1, 16'hFFFF, 1'b0);
        do_req(1'b0, 16'h0000, 1'b0);
        do_req(1'b0, 16'hFFFF, 1'b0);
        do_req(1'b1, 16'h0000, 1'b0);
        do_req(1'b0, 16'h0000, 1'b0);
        repeat (60) begin
            wr = (used.size() < 4) || $urandom_range(1);
            a = wr ? ADDR_W'($urandom) : used[$urandom_range(used.size() - 1)];
            do_req(wr, a, 1'($urandom));
        end
        // reset in mid-run leaves the device deselected and the wire released
        nrst_i = 1'b0;
        #5;
        cmp_bit("reset select", 1'b1, chip_select_low_o);
        cmp_bit("reset oe", 1'b0, data_in_oe_o);
        cmp_bit("reset strobe", 1'b1, write_strobe_low_o);
        cmp_bit("reset ready", 1'b1, req_ready_o);
        cmp_bit("reset rd valid", 1'b0, rd_valid_o);
        @(posedge clk_sys_i);
        #1;
        nrst_i = 1'b1;
        do_req(1'b0, 16'hFFFF, 1'b0);
        tally_and_finish();
    end
    initial begin
        #(CLK_PERIOD_NS * 5000);
        errors++;
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
